// ---- core/vipc_consts.vh ----
/*
  register offsets, field positions, reset values and vector constants
  for the vectored interrupt priority controller.
  assumes: included by bare name from core design files.
*/
`ifndef VIPC_CONSTS_VH
`define VIPC_CONSTS_VH

// apb byte offsets of the 17 controller registers plus core words
`define VIPC_OFF_GCTRL1   12'h000
`define VIPC_OFF_GCTRL2   12'h004
`define VIPC_OFF_FLAG0    12'h008
`define VIPC_OFF_ENA0     12'h018
`define VIPC_OFF_PRIO0    12'h028
`define VIPC_OFF_PEND     12'h040
`define VIPC_OFF_STATUS   12'h044
`define VIPC_OFF_CORE     12'h048
`define VIPC_OFF_VECADDR  12'h04C

// bank sizes: 4 flag, 4 enable, 6 priority words
`define VIPC_NWORDS       4
`define VIPC_NPRIO        6
`define VIPC_NSRC         24

// field positions
`define VIPC_NEST_BIT     15
`define VIPC_ALT_BIT      15
`define VIPC_LVL_LO       5
`define VIPC_TOP_BIT      3

// writable masks and reset values
`define VIPC_GCTRL1_MASK  16'h805E
`define VIPC_GCTRL2_MASK  16'h8007
`define VIPC_RESET16      16'h0000

// vector tables
`define VIPC_STD_BASE     24'h000004
`define VIPC_ALT_BASE     24'h000104
`define VIPC_FIRST_USER   7'h08
`define VIPC_EXT0_SRC     0
`define VIPC_EXT1_SRC     20
`define VIPC_EXT2_SRC     29

`endif

// ---- core/vipc_edge_det.v ----
/*
  edge detector for the three external request pins with polarity select.
  assumes: pins already synchronous to mclk.
*/
`timescale 1ns/1ps
module vipc_edge_det (
  // clock and reset
  input  wire       MCLK,
  input  wire       RST,
  input  wire       CE,
  // pins and polarity
  input  wire [2:0] pin,
  input  wire [2:0] falling_sel,
  // detected edge
  output wire [2:0] edge_hit
);
  reg [2:0] pin_q;
  reg       primed;

  // previous level of each pin; primed masks the first cycle after reset
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pin_q  <= 3'h0;
      primed <= 1'b0;
    end else if (CE) begin
      pin_q  <= pin;
      primed <= 1'b1;
    end
  end

  // polarity picks the edge
  // a pin idling high would otherwise look like an edge right after reset
  assign edge_hit = {3{primed}} & ((falling_sel & pin_q & ~pin) | (~falling_sel & ~pin_q & pin));
endmodule // vipc_edge_det

// ---- core/vipc_arbiter.v ----
/*
  combinational arbiter: highest-priority enabled pending source above
  the cpu level, lowest index on ties; traps beat all sources.
  assumes: inputs come from registers of the top module.
*/
`timescale 1ns/1ps
`include "vipc_consts.vh"
module vipc_arbiter (
  // requests
  input  wire [95:0] flags,
  input  wire [95:0] enables,
  input  wire [71:0] prios,
  input  wire [3:0]  trap_req,
  input  wire [3:0]  cpu_level,
  // result
  output reg         hit,
  output reg  [6:0]  vec,
  output reg  [3:0]  level
);
  integer i;
  reg [2:0] p;

  // trap level: lowest trap number gets the lowest trap level
  function [3:0] trap_level;
    input [1:0] n;
    begin
      trap_level = 4'hC + {2'b00, n};
    end
  endfunction

  always @* begin
    hit   = 1'b0;
    vec   = 7'h00;
    level = 4'h0;
    p     = 3'h0;
    for (i = `VIPC_NSRC - 1; i >= 0; i = i - 1) begin
      p = prios[i*3 +: 3];
      // level 7 and up masks users
      if (flags[i] && enables[i] && ({1'b0, p} > cpu_level) && (!hit || {1'b0, p} >= level)) begin
        hit   = 1'b1;
        vec   = `VIPC_FIRST_USER + i[6:0];
        level = {1'b0, p};
      end
    end
    for (i = 3; i >= 0; i = i - 1) begin
      // a trap at or below the running level waits, else it is re-presented forever
      if (trap_req[i] && trap_level(i[1:0]) > cpu_level) begin
        hit   = 1'b1;
        vec   = i[6:0] + 7'h01;
        level = trap_level(i[1:0]);
      end
    end
  end
endmodule // vipc_arbiter

// ---- core/vipc_top.v ----
/*
  vectored interrupt priority controller with apb register access.
  assumes: apb master on mclk; trap, source and pin inputs synchronous.
*/
// Overview of operation
// - seventeen controller registers: two controls, flags, enables, priorities, pending.
// - first control holds nesting disable and trap status flags.
// - second control holds pin edge polarity and alternate table select.
// - hardware sets request flags, only software clears them.
// - a source reaches the core only while enabled.
// - each source has a three-bit priority, eight levels.
// - pending register latches 7-bit vector and 4-bit new level.
// - sources map to bits in vector-table order, vector 8 at bit 0.
// - status word bits 7:5 hold writable low cpu level.
// - top level bit read-only so traps cannot be masked.
// - level bits binary 0 to 7; level 7 masks user interrupts.
// - top bit above low bits forms 4-bit level; set masks users.
// - nesting disable makes the level bits read-only.
// - nesting disabled blocks nesting; cleared permits it.
// - alternate select picks the alternate vector table.
// - polarity bit one requests on falling edge, zero rising, for pins 0 and 1; pin 2 maps to source 29 and sets no flag.
// - reset clears all controller registers.
`timescale 1ns/1ps
`include "vipc_consts.vh"
module vipc_top (
  // clock and reset
  input  wire        MCLK,
  input  wire        RST,
  input  wire        CE,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // request sources
  input  wire [23:0] SRC_EVENT,
  input  wire [2:0]  EXT_PIN,
  input  wire [3:0]  TRAP_EVENT,
  // core side
  input  wire        CORE_ACK,
  input  wire        CORE_RETURN,
  output reg         IRQ_VALID,
  output reg  [6:0]  IRQ_VECTOR,
  output reg  [23:0] IRQ_ADDR,
  output reg  [3:0]  CPU_LEVEL
);
  // register state
  reg  [15:0] global_ctrl_one;
  reg  [15:0] global_ctrl_two;
  reg  [95:0] request_flag_regs;
  reg  [95:0] source_enable_regs;
  reg  [95:0] source_priority_regs;
  reg  [15:0] pending_vector_status;
  reg  [2:0]  cpu_priority_level;
  reg         level_top_bit;
  reg  [3:0]  saved_level;
  reg         in_service;
  // derived
  wire        wr_acc;
  wire        rd_acc;
  wire [2:0]  pin_edge;
  wire        arb_hit;
  wire [6:0]  arb_vec;
  wire [3:0]  arb_level;
  wire [3:0]  level4;
  wire [3:0]  trap_req;
  wire [23:0] src_set;
  reg  [31:0] next_rdata;
  reg         next_err;

  // index of a bank word from an offset, or 4'hF when outside the bank
  function [3:0] bank_idx;
    input [11:0] addr;
    input [11:0] base;
    input [3:0]  count;
    reg   [11:0] d;
    begin
      d = addr - base;
      if (addr >= base && d[1:0] == 2'b00 && d[11:2] < {6'h00, count})
        bank_idx = d[5:2];
      else
        bank_idx = 4'hF;
    end
  endfunction

  // write lands on the edge that completes the transfer
  assign wr_acc = PSEL & PENABLE & PWRITE & PREADY;
  assign rd_acc = PSEL & PENABLE & ~PWRITE & ~PREADY;
  assign level4 = {level_top_bit, cpu_priority_level};
  // trap status bits 1..4 of first control drive trap requests
  assign trap_req = global_ctrl_one[4:1];

  // vector order sets pin source positions
  assign src_set = SRC_EVENT | ({23'h0, pin_edge[0]} << `VIPC_EXT0_SRC)
                 | ({23'h0, pin_edge[1]} << `VIPC_EXT1_SRC) | ({23'h0, pin_edge[2]} << `VIPC_EXT2_SRC);

  vipc_edge_det vipc_edge_det_inst (
    .MCLK        (MCLK),
    .RST         (RST),
    .CE          (CE),
    .pin         (EXT_PIN),
    .falling_sel (global_ctrl_two[2:0]),
    .edge_hit    (pin_edge)
  );

  vipc_arbiter vipc_arbiter_inst (
    .flags     (request_flag_regs),
    .enables   (source_enable_regs),
    .prios     (source_priority_regs[71:0]),
    .trap_req  (trap_req),
    .cpu_level (level4),
    .hit       (arb_hit),
    .vec       (arb_vec),
    .level     (arb_level)
  );

  always @* begin
    next_rdata = 32'h00000000;
    next_err   = 1'b0;
    if (bank_idx(PADDR, `VIPC_OFF_FLAG0, 4'h4) != 4'hF)
      next_rdata = {8'h00, request_flag_regs[bank_idx(PADDR, `VIPC_OFF_FLAG0, 4'h4)*24 +: 24]};
    else if (bank_idx(PADDR, `VIPC_OFF_ENA0, 4'h4) != 4'hF)
      next_rdata = {8'h00, source_enable_regs[bank_idx(PADDR, `VIPC_OFF_ENA0, 4'h4)*24 +: 24]};
    else if (bank_idx(PADDR, `VIPC_OFF_PRIO0, 4'h6) != 4'hF)
      next_rdata = {16'h0000, source_priority_regs[bank_idx(PADDR, `VIPC_OFF_PRIO0, 4'h6)*16 +: 16]};
    else begin
      case (PADDR)
        `VIPC_OFF_GCTRL1:  next_rdata = {16'h0000, global_ctrl_one};
        `VIPC_OFF_GCTRL2:  next_rdata = {16'h0000, global_ctrl_two};
        `VIPC_OFF_PEND:    next_rdata = {16'h0000, pending_vector_status};
        `VIPC_OFF_STATUS:  next_rdata = {24'h000000, cpu_priority_level, 5'h00};
        `VIPC_OFF_CORE:    next_rdata = {28'h0000000, level_top_bit, 3'h0};
        `VIPC_OFF_VECADDR: next_rdata = {8'h00, IRQ_ADDR};
        default:           next_err   = 1'b1;
      endcase
    end
  end

  // apb answer one cycle into access phase
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h00000000;
      PSLVERR <= 1'b0;
    end else if (CE) begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= PSEL & PENABLE & ~PREADY & next_err;
      if (rd_acc)
        PRDATA <= next_rdata;
    end
  end

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      global_ctrl_one       <= `VIPC_RESET16;
      global_ctrl_two       <= `VIPC_RESET16;
      request_flag_regs     <= 96'h0;
      source_enable_regs    <= 96'h0;
      source_priority_regs  <= 96'h0;
      pending_vector_status <= `VIPC_RESET16;
      cpu_priority_level    <= 3'h0;
      level_top_bit         <= 1'b0;
      saved_level           <= 4'h0;
      in_service            <= 1'b0;
      IRQ_VALID             <= 1'b0;
      IRQ_VECTOR            <= 7'h00;
      IRQ_ADDR              <= 24'h000000;
      CPU_LEVEL             <= 4'h0;
    end else if (CE) begin
      // control one write, trap flags writable
      if (wr_acc && PADDR == `VIPC_OFF_GCTRL1)
        global_ctrl_one <= PWDATA[15:0] & `VIPC_GCTRL1_MASK;
      if (wr_acc && PADDR == `VIPC_OFF_GCTRL2)
        global_ctrl_two <= PWDATA[15:0] & `VIPC_GCTRL2_MASK;
      if (wr_acc && bank_idx(PADDR, `VIPC_OFF_ENA0, 4'h4) != 4'hF)
        source_enable_regs[bank_idx(PADDR, `VIPC_OFF_ENA0, 4'h4)*24 +: 24] <= PWDATA[23:0];
      if (wr_acc && bank_idx(PADDR, `VIPC_OFF_PRIO0, 4'h6) != 4'hF)
        source_priority_regs[bank_idx(PADDR, `VIPC_OFF_PRIO0, 4'h6)*16 +: 16] <= PWDATA[15:0];
      if (wr_acc && bank_idx(PADDR, `VIPC_OFF_FLAG0, 4'h4) == 4'h0)
        request_flag_regs[23:0] <= PWDATA[23:0] | src_set;
      else
        request_flag_regs[23:0] <= request_flag_regs[23:0] | src_set;
      // trap events set status bits, set wins over software write
      if (|TRAP_EVENT)
        global_ctrl_one[4:1] <= ((wr_acc && PADDR == `VIPC_OFF_GCTRL1) ? PWDATA[4:1] : global_ctrl_one[4:1])
          | TRAP_EVENT;
      if (wr_acc && PADDR == `VIPC_OFF_STATUS && !global_ctrl_one[`VIPC_NEST_BIT])
        cpu_priority_level <= PWDATA[7:5];
      // top bit has no software write path; core return restores it
      // nesting disabled: no new request while in service
      if (arb_hit && !IRQ_VALID && !(in_service && global_ctrl_one[`VIPC_NEST_BIT])) begin
        IRQ_VALID  <= 1'b1;
        IRQ_VECTOR <= arb_vec;
        IRQ_ADDR   <= (global_ctrl_two[`VIPC_ALT_BIT] ? `VIPC_ALT_BASE : `VIPC_STD_BASE) + {16'h0, arb_vec, 1'b0};
        pending_vector_status <= {4'h0, arb_level, 1'b0, arb_vec};
      end else if (IRQ_VALID && CORE_ACK) begin
        IRQ_VALID          <= 1'b0;
        in_service         <= 1'b1;
        saved_level        <= level4;
        cpu_priority_level <= pending_vector_status[10:8];
        level_top_bit      <= pending_vector_status[11];
      end else if (CORE_RETURN && in_service) begin
        in_service         <= 1'b0;
        cpu_priority_level <= saved_level[2:0];
        level_top_bit      <= saved_level[3];
      end
      CPU_LEVEL <= level4;
    end
  end
endmodule // vipc_top

// ---- verif/vipc_top_asserts.sv ----
/*
  port checker for the interrupt controller top.
  assumes: bound to vipc_top from the bench top file.
*/
`timescale 1ns/1ps
module vipc_top_asserts (
  // clock and reset
  input wire        MCLK,
  input wire        RST,
  // apb
  input wire        PSEL,
  input wire        PENABLE,
  input wire [11:0] PADDR,
  input wire        PREADY,
  input wire        PSLVERR,
  // core side
  input wire [3:0]  TRAP_EVENT,
  input wire        CORE_ACK,
  input wire        IRQ_VALID,
  input wire [6:0]  IRQ_VECTOR,
  input wire [23:0] IRQ_ADDR,
  input wire [3:0]  CPU_LEVEL
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  // transfer and handshake steps
  sequence s_setup; PSEL && !PENABLE; endsequence
  sequence s_access; PSEL && PENABLE; endsequence
  sequence s_ack; IRQ_VALID && CORE_ACK; endsequence
  // apb answer timing
  AST_APB_ANSWER: assert property (s_setup ##1 s_access |-> ##[0:2] PREADY)
    else $error("apb access not answered");
  AST_RDY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("pready longer than one cycle");
  AST_RDY_ACCESS: assert property (PREADY |-> s_access)
    else $error("pready outside access phase");
  AST_ERR_ADDR: assert property (PSLVERR |-> PREADY && (PADDR > 12'h04C || PADDR[1:0] != 2'h0))
    else $error("error on mapped address");
  AST_VALID_HOLD: assert property (IRQ_VALID && !CORE_ACK |=> IRQ_VALID && $stable(IRQ_VECTOR))
    else $error("request dropped or changed before ack");
  AST_ACK_DROP: assert property (s_ack |=> !IRQ_VALID)
    else $error("request still up after ack");
  // low byte equal in both tables, so table select need not be seen
  AST_VEC_ADDR: assert property (IRQ_VALID |-> IRQ_ADDR[7:0] == 8'h04 + {IRQ_VECTOR, 1'b0})
    else $error("vector address mismatch");
  AST_USER_LEVEL: assert property ($rose(IRQ_VALID) && IRQ_VECTOR >= 7'h08 |=> CPU_LEVEL < 4'h7)
    else $error("user request at level seven or above");
  AST_TRAP_FIRST: assert property (TRAP_EVENT != 4'h0 && !IRQ_VALID |-> ##[1:2] (IRQ_VALID && IRQ_VECTOR < 7'h08))
    else $error("trap not presented first");
endmodule // vipc_top_asserts

// ---- verif/vipc_core_model.sv ----
/*
  core model: acks a pending request after a delay, returns on demand.
  assumes: bench pulses ret_go for one cycle.
*/
`timescale 1ns/1ps
module vipc_core_model #(parameter DELAY = 3) (
  // clock and reset
  input  wire MCLK,
  input  wire RST,
  // handshake
  input  wire irq_valid,
  input  wire ret_go,
  output reg  core_ack,
  output reg  core_return
);
  integer cnt;
  // slow ack, so the vector must stand meanwhile
  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cnt <= 0;
      core_ack <= 1'b0;
      core_return <= 1'b0;
    end else begin
      core_return <= ret_go;
      core_ack <= irq_valid && !core_ack && cnt == DELAY;
      cnt <= (irq_valid && !core_ack) ? cnt + 1 : 0;
    end
  end
endmodule // vipc_core_model

// ---- verif/test_vectored_interrupt_priority_ctrl.sv ----
/*
  bench for the interrupt controller: apb master, sources, core model.
  assumes: design constants header on the include path.
*/
`timescale 1ns/1ps
`include "vipc_consts.vh"
module test_vectored_interrupt_priority_ctrl;
  reg         MCLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, ret_go = 1'b0, err;
  reg  [11:0] PADDR = 12'h000;
  reg  [31:0] PWDATA = 32'h0, rd;
  reg  [23:0] SRC_EVENT = 24'h0;
  reg  [2:0]  EXT_PIN = 3'h0;
  reg  [3:0]  TRAP_EVENT = 4'h0;
  wire [31:0] PRDATA;
  wire [23:0] IRQ_ADDR;
  wire [6:0]  IRQ_VECTOR;
  wire [3:0]  CPU_LEVEL;
  wire        PREADY, PSLVERR, IRQ_VALID, CORE_ACK, CORE_RETURN;
  integer     n_fail = 0, compares = 0;
  always #5 MCLK = ~MCLK;
  vipc_top vipc_top_inst (.MCLK(MCLK), .RST(RST), .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SRC_EVENT(SRC_EVENT),
    .EXT_PIN(EXT_PIN), .TRAP_EVENT(TRAP_EVENT), .CORE_ACK(CORE_ACK), .CORE_RETURN(CORE_RETURN),
    .IRQ_VALID(IRQ_VALID), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_ADDR(IRQ_ADDR), .CPU_LEVEL(CPU_LEVEL));
  vipc_core_model vipc_core_model_inst (.MCLK(MCLK), .RST(RST), .irq_valid(IRQ_VALID), .ret_go(ret_go),
    .core_ack(CORE_ACK), .core_return(CORE_RETURN));
  // verdict, reached once
  task end_of_test;
    begin
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge MCLK);
  endtask
  // one apb transfer, held until pready is seen
  task apb(input w, input [11:0] a, input [31:0] d);
    integer k;
    begin
      PSEL <= 1'b1; PWRITE <= w; PADDR <= a; PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      k = 0;
      do begin @(posedge MCLK); k = k + 1; end while (PREADY !== 1'b1 && k < 20);
      if (k == 20) begin n_fail = n_fail + 1; end_of_test; end
      rd = PRDATA;
      err = PSLVERR;
      PSEL <= 1'b0; PENABLE <= 1'b0;
      // one idle edge, so a following call never re-drives psel in this step
      @(posedge MCLK);
    end
  endtask
  task wait_valid(input v);
    integer k;
    begin
      k = 0;
      while (IRQ_VALID !== v && k < 50) begin @(posedge MCLK); k = k + 1; end
      if (k == 50) begin n_fail = n_fail + 1; end_of_test; end
    end
  endtask
  // one request through to ack, level seen two edges later
  task service(input [6:0] v, input alt);
    begin
      wait_valid(1'b1);
      chk(IRQ_VECTOR, v);
      chk(IRQ_ADDR, (alt ? `VIPC_ALT_BASE : `VIPC_STD_BASE) + 2 * v);
      wait_valid(1'b0);
      tick(2);
    end
  endtask
  task src;
    begin SRC_EVENT <= 24'h1; tick(1); SRC_EVENT <= 24'h0; tick(4); end
  endtask
  // software clears the flag before return, else it requests again
  task clean;
    begin apb(1, `VIPC_OFF_FLAG0, 0); ret_go <= 1'b1; tick(1); ret_go <= 1'b0; tick(3); end
  endtask
  initial begin
    tick(10);
    RST <= 1'b0;
    tick(1);
    apb(0, `VIPC_OFF_GCTRL1, 0); chk(rd, 0);
    apb(0, `VIPC_OFF_STATUS, 0); chk(rd, 0);
    apb(0, 12'h100, 0); chk(err, 1); chk(rd, 0);
    // disabled source: flag only
    apb(1, `VIPC_OFF_PRIO0, 32'h5);
    src(); chk(IRQ_VALID, 0);
    apb(0, `VIPC_OFF_FLAG0, 0); chk(rd, 1);
    apb(1, `VIPC_OFF_ENA0, 1);
    service(8, 0); chk(CPU_LEVEL, 5);
    apb(0, `VIPC_OFF_PEND, 0); chk(rd, 32'h508);
    apb(0, `VIPC_OFF_FLAG0, 0); chk(rd, 1);
    clean(); chk(CPU_LEVEL, 0);
    // level seven masks, lowering it releases the request on the alternate table
    apb(1, `VIPC_OFF_GCTRL2, 32'h8000);
    apb(1, `VIPC_OFF_STATUS, 32'hE0); apb(0, `VIPC_OFF_STATUS, 0); chk(rd, 32'hE0);
    src(); chk(IRQ_VALID, 0); chk(CPU_LEVEL, 7);
    apb(1, `VIPC_OFF_STATUS, 0);
    service(8, 1); chk(CPU_LEVEL, 5);
    clean();
    // nesting disable freezes level bits; top level bit read only
    apb(1, `VIPC_OFF_GCTRL1, 32'h8000);
    apb(1, `VIPC_OFF_STATUS, 32'h60); apb(0, `VIPC_OFF_STATUS, 0); chk(rd, 0);
    apb(0, `VIPC_OFF_GCTRL1, 0); chk(rd, 32'h8000);
    apb(1, `VIPC_OFF_CORE, 32'h8); apb(0, `VIPC_OFF_CORE, 0); chk(rd, 0);
    // falling polarity on pin zero
    apb(1, `VIPC_OFF_GCTRL2, 32'h1);
    EXT_PIN <= 3'h1; tick(4); apb(0, `VIPC_OFF_FLAG0, 0); chk(rd, 0);
    EXT_PIN <= 3'h0;
    service(8, 0); chk(CPU_LEVEL, 5);
    // nesting disabled holds off a higher source until it is cleared
    apb(1, `VIPC_OFF_PRIO0, 32'h35); apb(1, `VIPC_OFF_ENA0, 32'h3);
    SRC_EVENT <= 24'h2; tick(1); SRC_EVENT <= 24'h0; tick(4); chk(IRQ_VALID, 0);
    apb(1, `VIPC_OFF_GCTRL1, 0);
    service(9, 0); chk(CPU_LEVEL, 6);
    // trap beats the level of the running handler
    apb(1, `VIPC_OFF_GCTRL1, 0);
    TRAP_EVENT <= 4'h1; tick(1); TRAP_EVENT <= 4'h0;
    service(1, 0); chk(CPU_LEVEL[3], 1);
    apb(0, `VIPC_OFF_PEND, 0); chk(rd, 32'hC01);
    end_of_test;
  end
endmodule // test_vectored_interrupt_priority_ctrl
bind vipc_top vipc_top_asserts vipc_top_asserts_inst (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
  .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .TRAP_EVENT(TRAP_EVENT), .CORE_ACK(CORE_ACK),
  .IRQ_VALID(IRQ_VALID), .IRQ_VECTOR(IRQ_VECTOR), .IRQ_ADDR(IRQ_ADDR), .CPU_LEVEL(CPU_LEVEL));
